/* adrc_device.sv */
// Purpose: Device end: reset sources, not-ready timing, register link
// Assumes: Link pins and supplies are asynchronous to CLK_SYS
// Notes:   16-bit frames, SPI mode 0, read bit first
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
module adrc_device (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  adrc_link_if.dev               LINK,
  input  wire logic              CORE_SUPPLY,
  input  wire logic              IO_SUPPLY,
  input  wire logic              REGULATOR_INPUT_SUPPLY,
  input  wire logic              CORE_FROM_REGULATOR,
  output logic                   READY,
  output logic                   RESET_FLAG,
  output logic                   EARLY_ACCESS_ERROR,
  output logic                   REGULATOR_OUT_EN,
  output adrc_pkg::adrc_byte_t   USER_CONFIG
);
  import adrc_pkg::*;

  // ----------------------------------------
  // Synchronisers and edges
  // ----------------------------------------
  logic [7:0]  raw;
  logic [7:0]  s;
  logic [7:0]  prev_q;
  logic        core, io, rin, cfr, rstn, sck, csn, sdi;
  logic        rst_fall, core_up, io_up, sck_rise, sck_fall, cs_fall, cs_rise;

  assign raw = {CORE_SUPPLY, IO_SUPPLY, REGULATOR_INPUT_SUPPLY, CORE_FROM_REGULATOR,
                LINK.rst_n_pin, LINK.sclk, LINK.cs_n, LINK.mosi};

  adrc_sync #(.W(8), .INI(DEV_SYNC_INI)) u_sync (
    .CLK_SYS (CLK_SYS),
    .RESET_N (RESET_N),
    .async_i (raw),
    .sync_o  (s)
  );

  assign {core, io, rin, cfr, rstn, sck, csn, sdi} = s;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      prev_q <= DEV_SYNC_INI;
    end else begin
      prev_q <= s;
    end
  end

  assign rst_fall = prev_q[3] & ~rstn;
  assign core_up  = ~prev_q[7] & core;
  assign io_up    = ~prev_q[6] & io;
  assign sck_rise = ~prev_q[2] & sck & ~csn;
  assign sck_fall = prev_q[2] & ~sck & ~csn;
  assign cs_fall  = prev_q[1] & ~csn;
  assign cs_rise  = ~prev_q[1] & csn;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  adrc_byte_t  if_cfg_q, setup_q, user_q;
  logic        reg_on_d, reg_on_q, reg_por, hw_wake, por_ext, por, sw_rst;
  logic [11:0] cnt_q, cnt_d, load;
  logic        busy, done, ready_q, flag_q, err_q;

  assign reg_on_d = rin & io & setup_q[REG_EN_POS];
  assign reg_por  = cfr & reg_on_d & ~reg_on_q;
  assign hw_wake  = rst_fall & cfr & ~setup_q[REG_EN_POS];
  assign por_ext  = (core_up & ~cfr) | io_up;
  assign por      = por_ext | reg_por;
  assign busy     = |cnt_q;
  assign done     = cnt_q == 12'h001;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      reg_on_q <= 1'b0;
    end else begin
      reg_on_q <= reg_on_d;
    end
  end

  // ----------------------------------------
  // Not-ready counter
  // ----------------------------------------
  always_comb begin
    load = 12'h000;
    if (~rstn) begin
      load = HW_RESET_WAIT_CYC;
    end
    if (hw_wake) begin
      load = adrc_max(load, WAKEUP_HW_CYC);
    end
    if (core_up & ~cfr) begin
      load = adrc_max(load, CORE_POWER_ON_CYC);
    end
    if (io_up) begin
      load = adrc_max(load, IO_POWER_ON_CYC);
    end
    if (reg_por) begin
      load = adrc_max(load, WAKEUP_CMD_CYC);
    end
    if (sw_rst) begin
      load = adrc_max(load, SW_RESET_WAIT_CYC);
    end
    cnt_d = adrc_max(load, busy ? cnt_q - 12'h001 : cnt_q);
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_q   <= CORE_POWER_ON_CYC;
      ready_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ready_q <= cnt_d == 12'h000;
    end
  end

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  logic [4:0]  bitc_q;
  logic [15:0] sh_q;
  logic        bad_q, end_ok, wr_ok, rd_ok, miso_q;
  logic [6:0]  addr, hdr_addr;
  adrc_byte_t  wdat, out_q, rdata;

  assign addr     = sh_q[14:8];
  assign wdat     = sh_q[7:0];
  assign end_ok   = cs_rise & (bitc_q == FRAME_BITS) & ~bad_q;
  assign wr_ok    = end_ok & ~sh_q[RW_POS];
  assign rd_ok    = end_ok & sh_q[RW_POS];
  assign hdr_addr = {sh_q[5:0], sdi};
  assign sw_rst   = wr_ok & (addr == A_IF_CFG) & wdat[SRST_HI_POS] & wdat[SRST_LO_POS];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      bitc_q <= 5'h00;
      sh_q   <= 16'h0000;
      bad_q  <= 1'b0;
    end else if (cs_fall) begin
      bitc_q <= 5'h00;
      bad_q  <= busy;
    end else begin
      if (~csn & busy) begin
        bad_q <= 1'b1;
      end
      if (sck_rise) begin
        sh_q <= {sh_q[14:0], sdi};
        if (bitc_q != FRAME_BITS) begin
          bitc_q <= bitc_q + 5'h01;
        end
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    case (hdr_addr)
      A_IF_CFG:   rdata = if_cfg_q;
      A_STATUS:   rdata[FLAG_POS] = flag_q;
      A_IF_STAT:  rdata[ERR_POS] = err_q;
      A_SETUP:    rdata = setup_q;
      A_USER_CFG: rdata = user_q;
      default:    rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      out_q  <= 8'h00;
      miso_q <= 1'b0;
    end else if (cs_fall) begin
      out_q  <= 8'h00;
      miso_q <= 1'b0;
    end else if (sck_rise && bitc_q == HDR_LAST) begin
      out_q <= (sh_q[6] & ~bad_q & ~busy) ? rdata : 8'h00;
    end else if (sck_fall) begin
      miso_q <= out_q[7];
      out_q  <= {out_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      if_cfg_q <= IF_CFG_DEF;
    end else if (rst_fall | por) begin
      if_cfg_q <= IF_CFG_DEF;
    end else if (wr_ok && addr == A_IF_CFG) begin
      if_cfg_q <= wdat;
    end else if (done) begin
      if_cfg_q[SRST_HI_POS] <= 1'b0;
      if_cfg_q[SRST_LO_POS] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      setup_q <= SETUP_DEF;
    end else if (rst_fall) begin
      setup_q <= SETUP_DEF;
      if (hw_wake) begin
        setup_q[REG_EN_POS] <= 1'b1;
      end
    end else if (por_ext | sw_rst) begin
      setup_q <= SETUP_DEF;
    end else if (wr_ok && addr == A_SETUP) begin
      setup_q <= wdat;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      user_q <= USER_CFG_DEF;
    end else if (rst_fall | por | sw_rst) begin
      user_q <= USER_CFG_DEF;
    end else if (wr_ok && addr == A_USER_CFG) begin
      user_q <= wdat;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      flag_q <= 1'b1;
    end else if (rst_fall | por | sw_rst) begin
      flag_q <= 1'b1;
    end else if (rd_ok && addr == A_STATUS) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      err_q <= 1'b0;
    end else if (cs_fall & busy) begin
      err_q <= 1'b1;
    end else if (wr_ok && addr == A_IF_STAT && wdat[ERR_POS]) begin
      err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign LINK.miso          = miso_q;
  assign READY              = ready_q;
  assign RESET_FLAG         = flag_q;
  assign EARLY_ACCESS_ERROR = err_q;
  assign REGULATOR_OUT_EN   = reg_on_q;
  assign USER_CONFIG        = user_q;
endmodule

/* adrc_device_reset_control_test.sv */
// Purpose: Self-checking bench joining host and device ends
// Assumes: Host reached over Avalon-MM, device status seen at its ports
// Notes:   Supplies and strap are driven by the bench
`timescale 1ns/100ps
module adrc_device_reset_control_test;
  import adrc_pkg::*;
  logic        clk_sys;
  logic        reset_n;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        core_supply;
  logic        io_supply;
  logic        reg_in_supply;
  logic        core_from_reg;
  logic        ready;
  logic        reset_flag;
  logic        early_err;
  logic        reg_out_en;
  adrc_byte_t  user_config;
  logic [31:0] rd;
  logic [7:0]  rb;
  int          num_errors;
  int          check_count;
  adrc_link_if link ();
  adrc_device adrc_device_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(link), .CORE_SUPPLY(core_supply),
    .IO_SUPPLY(io_supply), .REGULATOR_INPUT_SUPPLY(reg_in_supply), .CORE_FROM_REGULATOR(core_from_reg),
    .READY(ready), .RESET_FLAG(reset_flag), .EARLY_ACCESS_ERROR(early_err), .REGULATOR_OUT_EN(reg_out_en),
    .USER_CONFIG(user_config));
  adrc_host adrc_host_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .LINK(link));
  adrc_link_props adrc_link_props_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .rst_n_pin(link.rst_n_pin),
    .cs_n(link.cs_n), .CORE_SUPPLY(core_supply), .IO_SUPPLY(io_supply), .REGULATOR_INPUT_SUPPLY(reg_in_supply),
    .CORE_FROM_REGULATOR(core_from_reg), .READY(ready), .RESET_FLAG(reset_flag),
    .EARLY_ACCESS_ERROR(early_err), .REGULATOR_OUT_EN(reg_out_en));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic av_xfer(input logic [1:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check_val("avalon answer", 32'h1, {31'h0, n < 50});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      av_xfer(AV_STAT, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 3000);
    check_val("host idle", 32'h1, {31'h0, rd[0]});
  endtask
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d);
    wait_idle();
    av_xfer(AV_CMD, 1'b1, {16'h0000, rw, a, d});
    wait_idle();
    av_xfer(AV_RDATA, 1'b0, 32'h0);
    rb = rd[7:0];
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    check_val("ready", 1'b1, ready);
  endtask
  task automatic summarize();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end
  initial begin
    num_errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    core_supply = 1'b1;
    io_supply = 1'b1;
    reg_in_supply = 1'b1;
    core_from_reg = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check_val("ready", 1'b0, ready);
    check_val("user config", 32'h10, user_config);
    av_xfer(2'h3, 1'b1, 32'h5A);
    av_xfer(2'h3, 1'b0, 32'h0);
    check_val("unused word", 32'h0, rd);
    wait_idle();
    check_val("ready", 1'b1, ready);
    frame(1'b1, A_STATUS, 8'h00);
    check_val("status flag", 1'b1, rb[0]);
    check_val("reset flag", 1'b0, reset_flag);
    frame(1'b1, A_STATUS, 8'h00);
    check_val("status flag", 1'b0, rb[0]);
    frame(1'b0, A_USER_CFG, 8'h5A);
    frame(1'b0, A_IF_CFG, 8'h01);
    check_val("user config", 32'h5A, user_config);
    frame(1'b0, A_IF_CFG, 8'h81);
    check_val("user config", 32'h10, user_config);
    check_val("reset flag", 1'b1, reset_flag);
    check_val("ready", 1'b1, ready);
    frame(1'b1, A_IF_CFG, 8'h00);
    check_val("if config", 32'h0, rb);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      io_supply <= (i != 0);
      core_supply <= (i == 0);
      repeat (5) @(posedge clk_sys);
      io_supply <= 1'b1;
      core_supply <= 1'b1;
      repeat (4) @(posedge clk_sys);
      frame(1'b1, A_STATUS, 8'h00);
      check_val("early read", 32'h0, rb);
      check_val("early error", 1'b1, early_err);
      check_val("reset flag", 1'b1, reset_flag);
      wait_ready();
      frame(1'b1, A_IF_STAT, 8'h00);
      check_val("early bit", 32'h1, rb);
      frame(1'b0, A_IF_STAT, 8'h00);
      check_val("early error", 1'b1, early_err);
      frame(1'b0, A_IF_STAT, 8'h01);
      check_val("early error", 1'b0, early_err);
    end
    frame(1'b0, A_SETUP, 8'h01);
    check_val("regulator on", 1'b1, reg_out_en);
    frame(1'b1, A_STATUS, 8'h00);
    check_val("reset flag", 1'b0, reset_flag);
    reg_in_supply <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check_val("regulator on", 1'b0, reg_out_en);
    core_from_reg <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reg_in_supply <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check_val("regulator on", 1'b1, reg_out_en);
    check_val("reset flag", 1'b1, reset_flag);
    check_val("ready", 1'b0, ready);
    wait_ready();
    frame(1'b0, A_IF_CFG, 8'h81);
    check_val("regulator on", 1'b0, reg_out_en);
    frame(1'b1, A_STATUS, 8'h00);
    frame(1'b0, A_USER_CFG, 8'h5A);
    check_val("reset flag", 1'b0, reset_flag);
    check_val("user config", 32'h5A, user_config);
    wait_idle();
    av_xfer(AV_CMD, 1'b1, 32'h0001_0000);
    wait_idle();
    check_val("regulator on", 1'b1, reg_out_en);
    check_val("reset flag", 1'b1, reset_flag);
    check_val("user config", 32'h10, user_config);
    check_val("ready", 1'b1, ready);
    summarize();
  end
endmodule

/* adrc_host.sv */
// Purpose: Host end: drives reset pin and frames, keeps the waits
// Assumes: Avalon-MM master with waitrequest
// Notes:   Commands refused unless idle
`timescale 1ns/100ps
module adrc_host (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic [1:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  adrc_link_if.host        LINK
);
  import adrc_pkg::*;

  adrc_hst_t   st_q;
  logic [11:0] cnt_q, post;
  logic [3:0]  div_q;
  logic [5:0]  ph_q, ph_n;
  logic [15:0] tx_q, cmd_q;
  logic [7:0]  rx_q;
  logic [31:0] rdat_q, rd_v;
  logic        rstn_q, sclk_q, csn_q, mosi_q, wreq_q, init_q;
  logic        miso_s, cmd_wr, tick;

  adrc_sync #(.W(1), .INI(1'b0)) u_sync (
    .CLK_SYS (CLK_SYS),
    .RESET_N (RESET_N),
    .async_i (LINK.miso),
    .sync_o  (miso_s)
  );

  // ----------------------------------------
  // Avalon slave
  // ----------------------------------------
  assign cmd_wr = AVS_WRITE & ~wreq_q & (AVS_ADDRESS == AV_CMD) & (st_q == H_IDLE);

  always_comb begin
    rd_v = 32'h0000_0000;
    case (AVS_ADDRESS)
      AV_STAT:  rd_v[0] = st_q == H_IDLE;
      AV_RDATA: rd_v[7:0] = rx_q;
      default:  rd_v = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wreq_q <= 1'b1;
      rdat_q <= 32'h0000_0000;
    end else begin
      wreq_q <= ~((AVS_READ | AVS_WRITE) & wreq_q);
      if (AVS_READ & wreq_q) begin
        rdat_q <= rd_v;
      end
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  assign tick = div_q == 4'h0;
  assign ph_n = ph_q + 6'h01;

  always_comb begin
    post = FRAME_GAP_CYC;
    if (!cmd_q[RW_POS] && cmd_q[14:8] == A_IF_CFG && cmd_q[SRST_HI_POS] && cmd_q[SRST_LO_POS]) begin
      post = SW_RESET_WAIT_CYC;
    end else if (!cmd_q[RW_POS] && cmd_q[14:8] == A_SETUP && cmd_q[REG_EN_POS]) begin
      post = WAKEUP_CMD_CYC;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q   <= H_WAIT;
      cnt_q  <= CORE_POWER_ON_CYC;
      init_q <= 1'b1;
      rstn_q <= 1'b1;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      mosi_q <= 1'b0;
      div_q  <= 4'h0;
      ph_q   <= 6'h00;
      tx_q   <= 16'h0000;
      cmd_q  <= 16'h0000;
      rx_q   <= 8'h00;
    end else begin
      case (st_q)
        H_WAIT: begin
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else if (init_q) begin
            init_q <= 1'b0;
            rstn_q <= 1'b0;
            cnt_q  <= RESET_LOW_MIN_CYC;
            st_q   <= H_RSTLOW;
          end else begin
            st_q <= H_IDLE;
          end
        end
        H_RSTLOW: begin
          if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
          end else begin
            rstn_q <= 1'b1;
            cnt_q  <= HOST_HW_WAIT_CYC;
            st_q   <= H_WAIT;
          end
        end
        H_IDLE: begin
          if (cmd_wr && AVS_WRITEDATA[CMD_HW_POS]) begin
            rstn_q <= 1'b0;
            cnt_q  <= RESET_LOW_MIN_CYC;
            st_q   <= H_RSTLOW;
          end else if (cmd_wr) begin
            cmd_q  <= AVS_WRITEDATA[15:0];
            tx_q   <= AVS_WRITEDATA[15:0];
            mosi_q <= AVS_WRITEDATA[15];
            csn_q  <= 1'b0;
            div_q  <= SCLK_HALF_CYC - 4'h1;
            ph_q   <= 6'h00;
            st_q   <= H_FRAME;
          end
        end
        H_FRAME: begin
          if (!tick) begin
            div_q <= div_q - 4'h1;
          end else begin
            div_q <= SCLK_HALF_CYC - 4'h1;
            ph_q  <= ph_n;
            if (ph_n == HOST_END_PH) begin
              csn_q <= 1'b1;
              cnt_q <= post;
              st_q  <= H_WAIT;
            end else if (ph_n[0]) begin
              sclk_q <= 1'b1;
              rx_q   <= {rx_q[6:0], miso_s};
            end else begin
              sclk_q <= 1'b0;
              tx_q   <= {tx_q[14:0], 1'b0};
              mosi_q <= tx_q[14];
            end
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.rst_n_pin  = rstn_q;
  assign LINK.sclk       = sclk_q;
  assign LINK.cs_n       = csn_q;
  assign LINK.mosi       = mosi_q;
  assign AVS_READDATA    = rdat_q;
  assign AVS_WAITREQUEST = wreq_q;
endmodule

/* adrc_link_if.sv */
// Purpose: Pins between reset controller host and device
// Assumes: All pins push-pull, one driver each
// Notes:   No clocking block
`timescale 1ns/100ps
interface adrc_link_if;
  logic rst_n_pin;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input rst_n_pin, input sclk, input cs_n, input mosi, output miso);
  modport host (output rst_n_pin, output sclk, output cs_n, output mosi, input miso);
endinterface

/* adrc_link_props.sv */
// Purpose: Concurrent checks on the reset link and device status
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Takes link pins and device outputs as plain inputs
`timescale 1ns/100ps
module adrc_link_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic rst_n_pin,
  input wire logic cs_n,
  input wire logic CORE_SUPPLY,
  input wire logic IO_SUPPLY,
  input wire logic REGULATOR_INPUT_SUPPLY,
  input wire logic CORE_FROM_REGULATOR,
  input wire logic READY,
  input wire logic RESET_FLAG,
  input wire logic EARLY_ACCESS_ERROR,
  input wire logic REGULATOR_OUT_EN
);
  import adrc_pkg::*;
  logic [11:0] low_cnt_q;
  logic [11:0] low_cnt_d;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------
  // Reset pin low time
  // ----------------------------------------
  always_comb begin
    low_cnt_d = rst_n_pin ? 12'h000 : low_cnt_q + 12'h001;
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt_q <= 12'h000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence hw_fall_s;
    $fell(rst_n_pin);
  endsequence
  sequence early_frame_s;
    $fell(cs_n) ##0 (!READY) [*6];
  endsequence
  hw_reset_flag_a: assert property (hw_fall_s |-> ##[1:5] (RESET_FLAG && !READY))
    else $error("hw reset did not raise flag");
  early_error_a: assert property (early_frame_s |-> ##[0:4] EARLY_ACCESS_ERROR)
    else $error("early frame did not set error");
  release_not_ready_a: assert property ($rose(rst_n_pin) |-> (!READY) [*8])
    else $error("ready too soon after reset pin");
  reset_no_frame_a: assert property (!rst_n_pin |-> cs_n)
    else $error("frame during reset pin low");
  release_quiet_a: assert property ($rose(rst_n_pin) |-> cs_n [*8])
    else $error("frame right after reset pin");
  reset_low_min_a: assert property ($rose(rst_n_pin) |-> low_cnt_q >= RESET_LOW_MIN_CYC)
    else $error("reset pin low too short");
  io_por_flag_a: assert property ($rose(IO_SUPPLY) |-> ##[1:6] (RESET_FLAG && !READY))
    else $error("io supply rise without reset");
  core_por_flag_a: assert property ($rose(CORE_SUPPLY) && !CORE_FROM_REGULATOR |-> ##[1:6] (RESET_FLAG && !READY))
    else $error("core supply rise without reset");
  reg_supply_off_a: assert property ((!REGULATOR_INPUT_SUPPLY || !IO_SUPPLY) [*6] |-> !REGULATOR_OUT_EN)
    else $error("regulator on without supplies");
  reg_wake_por_a: assert property (CORE_FROM_REGULATOR && $rose(REGULATOR_OUT_EN) |-> ##[0:4] (RESET_FLAG && !READY))
    else $error("regulator turn-on without reset");
  hw_reg_enable_a: assert property (hw_fall_s ##0 (CORE_FROM_REGULATOR && !REGULATOR_OUT_EN && REGULATOR_INPUT_SUPPLY
                                    && IO_SUPPLY) |-> ##[1:8] REGULATOR_OUT_EN)
    else $error("hw reset left regulator off");
endmodule

/* adrc_pkg.sv */
// Purpose: Shared constants and types for the reset-control link
// Assumes: 20 MHz system clock on both ends
// Notes:   Times in ns, counts derived from them
package adrc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS               = 50;
  localparam int RESET_LOW_MIN_NS     = 10000;
  localparam int HW_RESET_WAIT_NS     = 20000;
  localparam int SW_RESET_WAIT_NS     = 10000;
  localparam int CORE_POWER_ON_WAIT_NS = 50000;
  localparam int IO_POWER_ON_WAIT_NS  = 50000;
  localparam int WAKEUP_COMMAND_WAIT_NS = 100000;
  localparam int WAKEUP_HW_WAIT_NS    = 150000;

  localparam logic [11:0] RESET_LOW_MIN_CYC   = 12'((RESET_LOW_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] HW_RESET_WAIT_CYC   = 12'((HW_RESET_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SW_RESET_WAIT_CYC   = 12'((SW_RESET_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CORE_POWER_ON_CYC   = 12'((CORE_POWER_ON_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] IO_POWER_ON_CYC     = 12'((IO_POWER_ON_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WAKEUP_CMD_CYC      = 12'((WAKEUP_COMMAND_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WAKEUP_HW_CYC       = 12'((WAKEUP_HW_WAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] HOST_HW_WAIT_CYC    = (WAKEUP_HW_CYC > HW_RESET_WAIT_CYC) ?
                                                WAKEUP_HW_CYC : HW_RESET_WAIT_CYC;
  localparam logic [11:0] FRAME_GAP_CYC       = 12'h001;
  localparam logic [3:0]  SCLK_HALF_CYC       = 4'h8;

  // ----------------------------------------
  // Device register map
  // ----------------------------------------
  typedef logic [7:0] adrc_byte_t;
  localparam logic [6:0] A_IF_CFG   = 7'h00;
  localparam logic [6:0] A_STATUS   = 7'h01;
  localparam logic [6:0] A_IF_STAT  = 7'h02;
  localparam logic [6:0] A_SETUP    = 7'h03;
  localparam logic [6:0] A_USER_CFG = 7'h04;
  localparam int SRST_HI_POS = 7;
  localparam int SRST_LO_POS = 0;
  localparam int FLAG_POS    = 0;
  localparam int ERR_POS     = 0;
  localparam int REG_EN_POS  = 0;
  localparam adrc_byte_t IF_CFG_DEF   = 8'h00;
  localparam adrc_byte_t SETUP_DEF    = 8'h00;
  localparam adrc_byte_t USER_CFG_DEF = 8'h10;

  // ----------------------------------------
  // Frame and host map
  // ----------------------------------------
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] HDR_LAST     = 5'h07;
  localparam int         RW_POS       = 15;
  localparam logic [5:0] HOST_END_PH  = 6'h21;
  localparam logic [7:0] DEV_SYNC_INI = 8'h0A;
  localparam logic [1:0] AV_CMD   = 2'h0;
  localparam logic [1:0] AV_STAT  = 2'h1;
  localparam logic [1:0] AV_RDATA = 2'h2;
  localparam int CMD_HW_POS = 16;

  typedef enum logic [3:0] {
    H_RSTLOW = 4'h1,
    H_WAIT   = 4'h2,
    H_IDLE   = 4'h4,
    H_FRAME  = 4'h8
  } adrc_hst_t;

  function automatic logic [11:0] adrc_max(input logic [11:0] a, input logic [11:0] b);
    adrc_max = (a > b) ? a : b;
  endfunction

endpackage

/* adrc_sync.sv */
// Purpose: Two-flop synchroniser for a bus of levels
// Assumes: Inputs are slow relative to the clock
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module adrc_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] INI = '0
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      meta_q <= INI;
      sync_o <= INI;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
